// ==== inc/stereo_sync_defines.svh ====
// Functional notes
// - While stereo input is active, sync information keeps the glasses' shutters aligned with the displayed frames.
// - In infrared mode a dedicated output carries the eye timing to the board's infrared transmitter.
// - In light-encoded mode exactly one light pulse is issued per frame, inside the both-shutters-closed interval.
// - While both shutters are closed the light source stays off except for that one pulse.
// - The pulse offset after subframe end alternates frame by frame between a base above 500 us and base plus delta.
// - The delta lies in 128 to 163 us with a nominal per frame rate, 161.6 us at 98 Hz.
// - The pulse width lies in 20 to 32 us with a nominal per frame rate, 31.8 us at 98 Hz.
// - The long offset always equals base plus delta exactly.
// - Rates 98, 100, 102, 118, 120 and 122 Hz are supported, each with its own nominal width and delta.
// - The sync pulse uses red light only, never blue.
`ifndef STEREO_SYNC_DEFINES_SVH
`define STEREO_SYNC_DEFINES_SVH

`define CLK_PERIOD_NS 50
`define NS2CYC(ns) ((ns) / `CLK_PERIOD_NS)
`define TIMER_W 16

`define BASE_OFFSET_NS 501000
`define BASE_OFFSET_MIN_NS 500000
`define WIDTH_MIN_NS 20000
`define WIDTH_MAX_NS 32000
`define DELTA_MIN_NS 128000
`define DELTA_MAX_NS 163000

`define WIDTH_98_NS 31800
`define WIDTH_100_NS 31200
`define WIDTH_102_NS 30600
`define WIDTH_118_NS 26400
`define WIDTH_120_NS 26000
`define WIDTH_122_NS 25600
`define DELTA_98_NS 161600
`define DELTA_100_NS 158400
`define DELTA_102_NS 155300
`define DELTA_118_NS 134200
`define DELTA_120_NS 132000
`define DELTA_122_NS 129800

`define RATE_98 3'h0
`define RATE_100 3'h1
`define RATE_102 3'h2
`define RATE_118 3'h3
`define RATE_120 3'h4
`define RATE_122 3'h5

`define RGB_OFF 3'h0
`define RGB_RED 3'h1

`endif

// ==== inc/stereo_sync_pkg.sv ====
package stereo_sync_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_OPEN,
    ST_OFFSET,
    ST_PULSE,
    ST_DARK
  } sync_state_t;
  typedef logic [2:0] rate_sel_t;
  // bit 0 red, bit 1 green, bit 2 blue
  typedef logic [2:0] rgb_t;
endpackage

// ==== inc/pulse_timer_if.sv ====
`timescale 1ns/1ps
interface pulse_timer_if #(parameter int unsigned TW = 16);
  logic load;
  logic [TW-1:0] count;
  logic busy;
  logic done;
  modport ctrl (output load, output count, input busy, input done);
  modport timer (input load, input count, output busy, output done);
endinterface // pulse_timer_if

// ==== logic/pulse_timer.sv ====
`timescale 1ns/1ps
`include "stereo_sync_defines.svh"
module pulse_timer #(
  parameter int unsigned TW = `TIMER_W
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic ce, // clock enable
  pulse_timer_if.timer tmr // load/count in, busy/done out
);
  import stereo_sync_pkg::*;

  logic [TW-1:0] cnt_reg;
  logic done_reg;

  // counts a loaded value down to zero; done pulses in the first cycle at zero, the same cycle in which busy drops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= 1'b0;
      if (tmr.load) begin
        cnt_reg <= tmr.count;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - TW'(1);
        if (cnt_reg == TW'(1)) begin
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign tmr.busy = (cnt_reg != '0);
  assign tmr.done = done_reg;
endmodule // pulse_timer

// ==== logic/stereo_sync_pulse.sv ====
`timescale 1ns/1ps
`include "stereo_sync_defines.svh"
module stereo_sync_pulse #(
  parameter int unsigned TW = `TIMER_W,
  parameter int unsigned BASE_OFFSET_CYC = `NS2CYC(`BASE_OFFSET_NS)
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic resetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic stereo_en, // stereo video input active
  input wire logic light_mode, // 1: light-encoded sync, 0: infrared sync
  input wire stereo_sync_pkg::rate_sel_t rate_sel, // internal frame rate select
  input wire logic frame_start, // pulse: new frame shown, shutter opens
  input wire logic subframe_end, // pulse: frame image ends, shutters close
  input wire stereo_sync_pkg::rgb_t illum_req, // normal illumination request
  output stereo_sync_pkg::rgb_t led_en, // illumination driver enables
  output logic ir_sync, // infrared transmitter key
  output logic left_eye, // 1 while the left-eye image is shown
  output logic shutters_closed, // both shutters closed interval
  output logic sync_pulse // high during the light sync pulse
);
  import stereo_sync_pkg::*;

  localparam int unsigned MAX_OFFSET_CYC = BASE_OFFSET_CYC + `NS2CYC(`DELTA_MAX_NS);

  generate
    if (BASE_OFFSET_CYC * `CLK_PERIOD_NS <= `BASE_OFFSET_MIN_NS) begin : g_bad_base
      $error("base offset must exceed its minimum");
    end
    if (MAX_OFFSET_CYC >= (64'd1 << TW)) begin : g_bad_width
      $error("timer width too small for the longest offset");
    end
  endgenerate

  sync_state_t state_reg, state_next;
  rate_sel_t rate_reg;
  logic light_reg;
  logic right_reg;
  logic [TW-1:0] width_cyc, delta_cyc;
  logic evt_start, evt_end;

  pulse_timer_if #(.TW(TW)) off_if ();
  pulse_timer_if #(.TW(TW)) wid_if ();

  pulse_timer #(.TW(TW)) u_offset_timer (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .tmr(off_if.timer)
  );

  pulse_timer #(.TW(TW)) u_width_timer (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .tmr(wid_if.timer)
  );

  assign evt_start = stereo_en && frame_start;
  assign evt_end = stereo_en && subframe_end;

  // nominal width and delta per internal frame rate
  always_comb begin
    case (rate_reg)
      `RATE_98: begin
        width_cyc = TW'(`NS2CYC(`WIDTH_98_NS));
        delta_cyc = TW'(`NS2CYC(`DELTA_98_NS));
      end
      `RATE_100: begin
        width_cyc = TW'(`NS2CYC(`WIDTH_100_NS));
        delta_cyc = TW'(`NS2CYC(`DELTA_100_NS));
      end
      `RATE_102: begin
        width_cyc = TW'(`NS2CYC(`WIDTH_102_NS));
        delta_cyc = TW'(`NS2CYC(`DELTA_102_NS));
      end
      `RATE_118: begin
        width_cyc = TW'(`NS2CYC(`WIDTH_118_NS));
        delta_cyc = TW'(`NS2CYC(`DELTA_118_NS));
      end
      `RATE_122: begin
        width_cyc = TW'(`NS2CYC(`WIDTH_122_NS));
        delta_cyc = TW'(`NS2CYC(`DELTA_122_NS));
      end
      default: begin
        width_cyc = TW'(`NS2CYC(`WIDTH_120_NS));
        delta_cyc = TW'(`NS2CYC(`DELTA_120_NS));
      end
    endcase
  end

  // offset timer armed at subframe end, width timer when the offset expires
  assign off_if.load = (state_reg == ST_OPEN) && evt_end && light_reg;
  // right-eye frames take the long offset, base plus delta exactly
  // done reaches the state one cycle after the count ends, so each timer is loaded one short
  assign off_if.count = TW'(BASE_OFFSET_CYC - 1) + (right_reg ? delta_cyc : '0);
  assign wid_if.load = (state_reg == ST_OFFSET) && off_if.done && !frame_start;
  assign wid_if.count = width_cyc - TW'(1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (evt_start) begin
          state_next = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (evt_end) begin
          state_next = light_reg ? ST_OFFSET : ST_DARK;
        end
      end
      ST_OFFSET: begin
        if (evt_start) begin
          state_next = ST_OPEN;
        end else if (off_if.done) begin
          state_next = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (evt_start) begin
          state_next = ST_OPEN;
        end else if (wid_if.done) begin
          state_next = ST_DARK;
        end
      end
      ST_DARK: begin
        if (evt_start) begin
          state_next = ST_OPEN;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (!stereo_en) begin
      state_next = ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // rate and mode only change on a frame boundary, or on any cycle while in ST_OFF
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rate_reg <= `RATE_98;
      light_reg <= 1'b0;
    end else if (ce && (evt_start || state_reg == ST_OFF)) begin
      rate_reg <= rate_sel;
      light_reg <= light_mode;
    end
  end

  // eye phase: first frame after start is left, then alternates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      right_reg <= 1'b1;
    end else if (ce) begin
      if (!stereo_en) begin
        right_reg <= 1'b1;
      end else if (frame_start) begin
        right_reg <= !right_reg;
      end
    end
  end

  // illumination: normal while open, dark when closed except a red pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      led_en <= `RGB_OFF;
      sync_pulse <= 1'b0;
      shutters_closed <= 1'b0;
    end else if (ce) begin
      case (state_next)
        ST_OFF, ST_OPEN: led_en <= illum_req;
        ST_PULSE: led_en <= `RGB_RED;
        default: led_en <= `RGB_OFF;
      endcase
      sync_pulse <= (state_next == ST_PULSE);
      shutters_closed <= (state_next == ST_OFFSET) || (state_next == ST_PULSE)
        || (state_next == ST_DARK);
    end
  end

  // eye outputs follow the phase that the next state shows
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_eye <= 1'b0;
      ir_sync <= 1'b0;
    end else if (ce) begin
      if (!stereo_en) begin
        left_eye <= 1'b0;
        ir_sync <= 1'b0;
      end else if (frame_start) begin
        left_eye <= right_reg;
        ir_sync <= right_reg && !light_mode;
      end
    end
  end
endmodule // stereo_sync_pulse

// ==== dv/stereo_sync_checker.sv ====
`timescale 1ns/1ps
module stereo_sync_checker #(parameter int unsigned BASE_OFFSET_CYC = 10020) (
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic ce, // enable
  input wire logic stereo_en, // stereo on
  input wire logic frame_start, // frame
  input wire stereo_sync_pkg::rgb_t illum_req, // request
  input wire stereo_sync_pkg::rgb_t led_en, // leds
  input wire logic ir_sync, // ir key
  input wire logic left_eye, // eye
  input wire logic shutters_closed, // closed
  input wire logic sync_pulse // pulse
);
  import stereo_sync_pkg::*;
  logic [15:0] dark_cnt;
  logic [15:0] lit_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) dark_cnt <= 16'h0000;
    else if (!shutters_closed) dark_cnt <= 16'h0000;
    else if (!sync_pulse) dark_cnt <= dark_cnt + 16'h0001;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lit_cnt <= 16'h0000;
    else if (!sync_pulse) lit_cnt <= 16'h0000;
    else lit_cnt <= lit_cnt + 16'h0001;
  end
  chk_pulse_red_only: assert property (sync_pulse |-> led_en == 3'h1)
    else $error("sync pulse not red only");
  chk_dark_after_pulse: assert property ($fell(sync_pulse) && shutters_closed |-> led_en == 3'h0)
    else $error("light after sync pulse");
  chk_pulse_when_closed: assert property (sync_pulse |-> shutters_closed)
    else $error("pulse outside closed interval");
  chk_ir_left_only: assert property (ir_sync |-> left_eye)
    else $error("ir key outside left frame");
  chk_eye_alternates: assert property (ce && stereo_en && frame_start && left_eye |=> !left_eye)
    else $error("eye did not alternate");
  chk_open_on_start: assert property (ce && stereo_en && frame_start |=> !shutters_closed && !sync_pulse)
    else $error("shutters not opened");
  chk_idle_outputs: assert property (ce && !stereo_en |=> !shutters_closed && !sync_pulse && !ir_sync && led_en == $past(illum_req))
    else $error("idle outputs wrong");
  chk_freeze_hold: assert property (!ce |=> $stable(left_eye) && $stable(shutters_closed))
    else $error("state moved while disabled");
  chk_offset_span: assert property ($rose(sync_pulse) |-> dark_cnt > 16'h2710 && (dark_cnt == BASE_OFFSET_CYC || (dark_cnt - BASE_OFFSET_CYC >= 16'h0A00 && dark_cnt - BASE_OFFSET_CYC <= 16'h0CBC)))
    else $error("pulse offset out of range");
  chk_width_span: assert property ($fell(sync_pulse) |-> lit_cnt >= 16'h0190 && lit_cnt <= 16'h0280)
    else $error("pulse width out of range");
endmodule // stereo_sync_checker
bind stereo_sync_pulse stereo_sync_checker #(.BASE_OFFSET_CYC(BASE_OFFSET_CYC)) stereo_sync_checker_inst (
  .clk(clk), .resetn(resetn), .ce(ce), .stereo_en(stereo_en), .frame_start(frame_start),
  .illum_req(illum_req), .led_en(led_en), .ir_sync(ir_sync), .left_eye(left_eye),
  .shutters_closed(shutters_closed), .sync_pulse(sync_pulse));

// ==== dv/light_sensor_model.sv ====
`timescale 1ns/1ps
module light_sensor_model (
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic shutters_closed, // closed window
  input wire stereo_sync_pkg::rgb_t led_en, // light source
  output logic [15:0] dark_cnt, // dark cycles before pulse
  output logic [15:0] lit_cnt, // red pulse cycles
  output logic [15:0] n_pulses // pulses in window
);
  import stereo_sync_pkg::*;
  logic closed_d;
  logic red_d;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      closed_d <= 1'b0;
      red_d <= 1'b0;
      dark_cnt <= 16'h0000;
      lit_cnt <= 16'h0000;
      n_pulses <= 16'h0000;
    end else begin
      closed_d <= shutters_closed;
      red_d <= led_en == 3'h1;
      if (shutters_closed && !closed_d) begin
        dark_cnt <= 16'h0001;
        lit_cnt <= 16'h0000;
        n_pulses <= 16'h0000;
      end else if (shutters_closed) begin
        if (led_en == 3'h0 && n_pulses == 16'h0000) dark_cnt <= dark_cnt + 16'h0001;
        if (led_en == 3'h1) lit_cnt <= lit_cnt + 16'h0001;
        if (led_en == 3'h1 && !red_d) n_pulses <= n_pulses + 16'h0001;
      end
    end
  end
endmodule // light_sensor_model

// ==== dv/stereo_sync_pulse_test.sv ====
`timescale 1ns/1ps
module stereo_sync_pulse_test;
  import stereo_sync_pkg::*;
  localparam int BASE = 10020;
  int width_tab [6] = '{636, 624, 612, 528, 520, 512};
  int delta_tab [6] = '{3232, 3168, 3106, 2684, 2640, 2596};
  int n_errors = 0;
  int checks_done = 0;
  logic clk, resetn, ce, stereo_en, light_mode, frame_start, subframe_end;
  logic ir_sync, left_eye, shutters_closed, sync_pulse;
  rate_sel_t rate_sel;
  rgb_t illum_req, led_en;
  logic [15:0] dark_cnt, lit_cnt, n_pulses;
  stereo_sync_pulse #(.BASE_OFFSET_CYC(BASE)) stereo_sync_pulse_inst (.clk(clk), .resetn(resetn),
    .ce(ce), .stereo_en(stereo_en), .light_mode(light_mode), .rate_sel(rate_sel),
    .frame_start(frame_start), .subframe_end(subframe_end), .illum_req(illum_req),
    .led_en(led_en), .ir_sync(ir_sync), .left_eye(left_eye),
    .shutters_closed(shutters_closed), .sync_pulse(sync_pulse));
  light_sensor_model light_sensor_model_inst (.clk(clk), .resetn(resetn),
    .shutters_closed(shutters_closed), .led_en(led_en), .dark_cnt(dark_cnt),
    .lit_cnt(lit_cnt), .n_pulses(n_pulses));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic strobe(input bit at_end);
    frame_start = !at_end;
    subframe_end = at_end;
    @(negedge clk);
    frame_start = 1'b0;
    subframe_end = 1'b0;
    @(negedge clk);
  endtask
  task automatic light_frame(input int r, input bit left);
    int o;
    o = BASE + (left ? 0 : delta_tab[r]);
    rate_sel = r[2:0];
    strobe(1'b0);
    check(left_eye, left);
    check(ir_sync, 1'b0);
    check(led_en, illum_req);
    repeat (20) @(negedge clk);
    strobe(1'b1);
    repeat (o) @(negedge clk);
    check(sync_pulse, 1'b1);
    check(led_en, 3'h1);
    check(shutters_closed, 1'b1);
    repeat (width_tab[r] + 10) @(negedge clk);
    check(dark_cnt, o[15:0]);
    check(lit_cnt, width_tab[r][15:0]);
    check(n_pulses, 16'h0001);
    check(led_en, 3'h0);
    check(sync_pulse, 1'b0);
  endtask
  task automatic light_seq();
    light_mode = 1'b1;
    stereo_en = 1'b1;
    @(negedge clk);
    for (int r = 0; r < 6; r++) begin
      light_frame(r, r % 2 == 0);
    end
  endtask
  task automatic ir_seq();
    stereo_en = 1'b0;
    light_mode = 1'b0;
    repeat (2) @(negedge clk);
    check(led_en, illum_req);
    check(shutters_closed, 1'b0);
    stereo_en = 1'b1;
    @(negedge clk);
    strobe(1'b0);
    check(ir_sync, 1'b1);
    ce = 1'b0;
    strobe(1'b0);
    ce = 1'b1;
    check(left_eye, 1'b1);
    strobe(1'b1);
    check(shutters_closed, 1'b1);
    repeat (BASE + 700) @(negedge clk);
    check(n_pulses, 16'h0000);
    strobe(1'b0);
    check(ir_sync, 1'b0);
    check(left_eye, 1'b0);
  endtask
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    stereo_en = 1'b0;
    light_mode = 1'b1;
    rate_sel = 3'h0;
    frame_start = 1'b0;
    subframe_end = 1'b0;
    illum_req = 3'h7;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    light_seq();
    ir_seq();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule // stereo_sync_pulse_test
